// >>> rtl/nfc_host_ctrl.sv
// Host-side controller that drives an asynchronous parallel NOR flash.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Read drives select and gate low, strobe high, reset high; device returns data.
// - Write drives select low, gate high, strobe low, reset high.
// - Host keeps output gate high through the whole write cycle.
// - After reset rises host waits read or write wake delay.
// - Select toggled between reads forces full random access latency.
module nfc_host_ctrl
  import nfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire nfc_req_type req,
  input wire logic reqValid,
  input wire logic resetReq,
  input wire logic writeProtReq,
  output logic reqReady,
  output logic [15:0] rdData,
  output logic rdValid,
  output nfc_ctl_type ctl,
  output logic [25:0] addrOut,
  output logic [15:0] dqOut,
  output logic [15:0] dqOe,
  input wire logic [15:0] dqIn
);

  nfc_state_type state_q;
  logic load;
  logic [7:0] loadValue;
  logic done;
  logic pageValid_q;
  logic [25:0] pageBase_q;
  logic curByte_q;
  logic readWake_q;
  logic [15:0] dqSync1_q;
  logic [15:0] dqSync2_q;
  logic [15:0] dqSync3_q;
  logic samePage;

  nfc_delay_counter timer
  (
    .clk(clk),
    .rst(rst),
    .load(load),
    .loadValue(loadValue),
    .done(done)
  );

  // ************************************************************
  // Data input synchroniser
  // ************************************************************
  // Three stages; data is sampled only after the access latency so the
  // agreeing second and third stages carry a stable word.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dqSync1_q <= 16'h0000;
      dqSync2_q <= 16'h0000;
      dqSync3_q <= 16'h0000;
    end
    else
    begin
      dqSync1_q <= dqIn;
      dqSync2_q <= dqSync1_q;
      dqSync3_q <= dqSync2_q;
    end
  end

  // A page hit needs the same page, same width, and select kept low.
  assign samePage = pageValid_q && (req.byteMode == curByte_q) &&
    (req.addr[25:PAGE_BITS + 1] == pageBase_q[25:PAGE_BITS + 1]) &&
    (curByte_q || (req.addr[PAGE_BITS] == pageBase_q[PAGE_BITS]));

  // ************************************************************
  // Timer load control
  // ************************************************************
  always_comb
  begin
    load = 1'b0;
    loadValue = CNT_ZERO;
    case (state_q)
      ST_RESET:
      begin
        if (done && !resetReq)
        begin
          load = 1'b1;
          loadValue = 8'(WWAKE_CYC > RWAKE_CYC ? WWAKE_CYC : RWAKE_CYC);
        end
      end
      ST_IDLE:
      begin
        if (resetReq)
        begin
          load = 1'b1;
          loadValue = 8'(RSTLOW_CYC);
        end
        else if (reqValid && req.write)
        begin
          load = 1'b1;
          loadValue = 8'(SETUP_CYC);
        end
        else if (reqValid)
        begin
          load = 1'b1;
          // Extra three cycles cover the input synchroniser depth.
          loadValue = 8'((samePage ? PAGE_CYC : RANDOM_CYC) + 3);
        end
      end
      ST_WSETUP:
      begin
        if (done)
        begin
          load = 1'b1;
          loadValue = 8'(WPULSE_CYC);
        end
      end
      ST_WPULSE:
      begin
        if (done)
        begin
          load = 1'b1;
          loadValue = 8'(SETUP_CYC);
        end
      end
      default:
      begin
        load = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Bus sequencer
  // ************************************************************
  // Every strobe phase is at least one 25 ns cycle, far above the glitch
  // filter window, so no legitimate edge is discarded.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= ST_RESET;
    else
    begin
      case (state_q)
        ST_RESET:
          if (done && !resetReq)
            state_q <= ST_WAKE;
        ST_WAKE:
          if (done)
            state_q <= ST_IDLE;
        ST_IDLE:
          if (resetReq)
            state_q <= ST_RESET;
          else if (reqValid && req.write)
            state_q <= ST_WSETUP;
          else if (reqValid)
            state_q <= ST_READ;
        ST_READ:
          if (done)
            state_q <= ST_IDLE;
        ST_WSETUP:
          if (done)
            state_q <= ST_WPULSE;
        ST_WPULSE:
          if (done)
            state_q <= ST_WHOLD;
        ST_WHOLD:
          if (done)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_RESET;
      endcase
    end
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  // Select stays low across back-to-back reads so page hits are legal;
  // a write or reset ends the page.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctl <= '{chipSelN: 1'b1, outGateN: 1'b1, writeStrobeN: 1'b1,
               hardResetN: 1'b0, byteWideN: 1'b1, writeProtN: 1'b0};
      addrOut <= 26'h0000000;
      dqOut <= 16'h0000;
      dqOe <= 16'h0000;
    end
    else
    begin
      ctl.writeProtN <= !writeProtReq;
      ctl.hardResetN <= !((state_q == ST_IDLE && resetReq) ||
        (state_q == ST_RESET && !(done && !resetReq)));
      if (state_q == ST_IDLE && reqValid && !resetReq)
      begin
        ctl.byteWideN <= !req.byteMode;
        addrOut <= req.addr;
        // In byte mode the top data pin carries the lowest address bit.
        dqOut <= req.byteMode ? {req.addr[0], 7'h00, req.wdata[7:0]}
                              : req.wdata;
        if (req.write)
        begin
          ctl.chipSelN <= 1'b0;
          ctl.outGateN <= 1'b1;
          dqOe <= req.byteMode ? 16'h80ff : 16'hffff;
        end
        else
        begin
          ctl.chipSelN <= 1'b0;
          ctl.outGateN <= 1'b0;
          // Release data lines before the device drives them.
          dqOe <= req.byteMode ? 16'h8000 : 16'h0000;
        end
      end
      else if (state_q == ST_WSETUP && done)
        ctl.writeStrobeN <= 1'b0;
      else if (state_q == ST_WPULSE && done)
        ctl.writeStrobeN <= 1'b1;
      else if (state_q == ST_WHOLD && done)
      begin
        // Deselecting is safe here: a started program or erase runs on.
        ctl.chipSelN <= 1'b1;
        dqOe <= 16'h0000;
      end
      else if (state_q == ST_READ && done)
        ctl.outGateN <= 1'b1;
      else if (resetReq || state_q == ST_RESET)
      begin
        ctl.chipSelN <= 1'b1;
        ctl.outGateN <= 1'b1;
        dqOe <= 16'h0000;
      end
    end
  end

  // ************************************************************
  // Page tracking and read return
  // ************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pageValid_q <= 1'b0;
      pageBase_q <= 26'h0000000;
      curByte_q <= 1'b0;
      rdData <= 16'h0000;
      rdValid <= 1'b0;
      reqReady <= 1'b0;
      readWake_q <= 1'b0;
    end
    else
    begin
      rdValid <= 1'b0;
      reqReady <= (state_q == ST_IDLE) && !reqValid && !resetReq;
      readWake_q <= (state_q == ST_WAKE);
      if (state_q == ST_IDLE && reqValid && !resetReq && !req.write)
      begin
        pageValid_q <= 1'b1;
        pageBase_q <= req.addr;
        curByte_q <= req.byteMode;
      end
      else if (state_q != ST_IDLE && state_q != ST_READ)
        pageValid_q <= 1'b0;
      if (state_q == ST_READ && done)
      begin
        rdValid <= 1'b1;
        rdData <= curByte_q ? {8'h00, dqSync3_q[7:0]} : dqSync3_q;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_write_gate_high: assert property (@(posedge clk) disable iff (rst)
    !ctl.writeStrobeN |-> ctl.outGateN)
    else $error("Output gate low during write strobe.");
  a_read_levels: assert property (@(posedge clk) disable iff (rst)
    !ctl.outGateN |-> !ctl.chipSelN && ctl.writeStrobeN && ctl.hardResetN)
    else $error("Read pin levels wrong.");
  a_write_levels: assert property (@(posedge clk) disable iff (rst)
    !ctl.writeStrobeN |-> !ctl.chipSelN && ctl.hardResetN)
    else $error("Write pin levels wrong.");
  a_gate_releases_bus: assert property (@(posedge clk) disable iff (rst)
    !ctl.outGateN |-> (dqOe[14:0] == 15'h0000))
    else $error("Host drives data while output gate low.");
  a_strobe_width: assert property (@(posedge clk) disable iff (rst)
    $fell(ctl.writeStrobeN) |-> !ctl.writeStrobeN[*2])
    else $error("Write strobe pulse too short.");
  a_wake_wait: assert property (@(posedge clk) disable iff (rst)
    $rose(ctl.hardResetN) |-> ctl.chipSelN[*8])
    else $error("Access started before wake delay.");
  a_reset_deselect: assert property (@(posedge clk) disable iff (rst)
    !ctl.hardResetN && $past(!ctl.hardResetN) |-> ctl.chipSelN)
    else $error("Select low during reset.");
  a_data_held: assert property (@(posedge clk) disable iff (rst)
    $rose(ctl.writeStrobeN) |-> !ctl.chipSelN && dqOe[0])
    else $error("Data released before strobe rose.");
  a_read_return: assert property (@(posedge clk) disable iff (rst)
    $fell(ctl.outGateN) |-> ##[5:9] rdValid)
    else $error("Read data not returned in time.");
  c_read: cover property (@(posedge clk) disable iff (rst) rdValid);
  c_write: cover property (@(posedge clk) disable iff (rst)
    $rose(ctl.writeStrobeN));
  c_reset: cover property (@(posedge clk) disable iff (rst)
    $rose(ctl.hardResetN));

endmodule // nfc_host_ctrl
`default_nettype wire

// >>> rtl/nfc_pkg.sv
// Package of constants and carrier types for the NOR flash bus controller.
package nfc_pkg;

  // ************************************************************
  // Widths and map
  // ************************************************************
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int PAGE_WORDS = 16;
  localparam int PAGE_BITS = 4;
  localparam int BLOCK_WORDS = 65536;
  localparam logic [25:0] TOP_WORD_ADDR = 26'h3ffffff;

  // ************************************************************
  // Timing in nanoseconds and derived cycle counts at 40 MHz
  // ************************************************************
  localparam int CLK_NS = 25;
  localparam int RANDOM_ACCESS_LATENCY_NS = 110;
  localparam int PAGE_ACCESS_LATENCY_NS = 20;
  localparam int READ_WAKE_DELAY_NS = 200;
  localparam int WRITE_WAKE_DELAY_NS = 200;
  localparam int RESET_LOW_NS = 500;
  localparam int WRITE_PULSE_NS = 50;
  localparam int SETUP_NS = 25;
  localparam int GLITCH_NS = 3;

  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RANDOM_CYC = ceil_cycles(RANDOM_ACCESS_LATENCY_NS);
  localparam int PAGE_CYC = ceil_cycles(PAGE_ACCESS_LATENCY_NS);
  localparam int RWAKE_CYC = ceil_cycles(READ_WAKE_DELAY_NS);
  localparam int WWAKE_CYC = ceil_cycles(WRITE_WAKE_DELAY_NS);
  localparam int RSTLOW_CYC = ceil_cycles(RESET_LOW_NS);
  localparam int WPULSE_CYC = ceil_cycles(WRITE_PULSE_NS);
  localparam int SETUP_CYC = ceil_cycles(SETUP_NS);
  localparam logic [7:0] CNT_ZERO = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0]
  {
    ST_RESET = 3'b000,
    ST_WAKE = 3'b001,
    ST_IDLE = 3'b010,
    ST_READ = 3'b011,
    ST_WSETUP = 3'b100,
    ST_WPULSE = 3'b101,
    ST_WHOLD = 3'b110
  } nfc_state_type;

  typedef struct packed
  {
    logic [25:0] addr;
    logic [15:0] wdata;
    logic write;
    logic byteMode;
  } nfc_req_type;

  typedef struct packed
  {
    logic chipSelN;
    logic outGateN;
    logic writeStrobeN;
    logic hardResetN;
    logic byteWideN;
    logic writeProtN;
  } nfc_ctl_type;

endpackage : nfc_pkg

// >>> rtl/nfc_delay_counter.sv
// Loadable down counter used for every bus timing interval.
`timescale 1ns/100ps
`default_nettype none
module nfc_delay_counter
  import nfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] loadValue,
  output logic done
);

  logic [7:0] count_q;

  // ************************************************************
  // Counter
  // ************************************************************
  // Loading restarts the interval; done is high once it reaches zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_q <= CNT_ZERO;
    else if (load)
      count_q <= loadValue;
    else if (count_q != CNT_ZERO)
      count_q <= count_q - 8'h01;
  end

  // Done looks at the count alone, so a caller may load on done without
  // closing a combinational loop through this counter.
  assign done = (count_q == CNT_ZERO);

endmodule // nfc_delay_counter
`default_nettype wire

// >>> testbench/nfc_flash_model.sv
// Behavioural model of the parallel NOR flash at the controller's far side.
`timescale 1ns/100ps
`default_nettype none
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter int WAKE_NS = 200,
  parameter int RAND_NS = 110,
  parameter int PAGE_NS = 20
)
(
  input wire nfc_ctl_type ctl,
  input wire logic [25:0] addrOut,
  input wire logic [15:0] dqOut,
  input wire logic [15:0] dqOe,
  output logic [15:0] dqIn,
  output var int faults,
  output logic [25:0] wrAddr,
  output logic [15:0] wrData,
  output logic wrLow
);
  logic selW;
  logic rdOn;
  logic vld = 1'b0;
  logic [15:0] junk = 16'h3cc3;
  logic [21:0] pg = 22'h3fffff;
  realtime chg = 0;
  realtime csFall = 0;
  realtime wake = 0;
  realtime lat = RAND_NS;
  int wakeFaults = 0;
  int busFaults = 0;

  // ****
  // Bus decode
  // ****
  // Reset low wins over every strobe, so both windows close under it.
  assign selW = !ctl.chipSelN && !ctl.writeStrobeN
    && ctl.hardResetN;
  assign rdOn = !ctl.chipSelN && !ctl.outGateN && ctl.writeStrobeN
    && ctl.hardResetN;

  // ****
  // Write latching
  // ****
  // Address on the later falling edge, data on the earlier rising edge.
  assign faults = wakeFaults + busFaults;
  always @(posedge selW)
  begin
    wrAddr = addrOut;
    wrLow = dqOut[15];
  end
  always @(negedge selW)
    wrData = dqOut;

  // ****
  // Read timing and host discipline
  // ****
  // A new page costs the full latency, a page neighbour the short one.
  always @(addrOut)
  begin
    lat = (addrOut[25:4] == pg) ? PAGE_NS : RAND_NS;
    pg = addrOut[25:4];
    chg = $realtime;
  end
  // Any select access too soon after wake-up is logged as a host fault.
  always @(negedge ctl.chipSelN)
  begin
    csFall = $realtime;
    if ($realtime - wake < WAKE_NS)
      wakeFaults++;
  end
  always @(posedge ctl.hardResetN)
    wake = $realtime;
  // Polling is off the rising clock edges, so it never races the host's updates.
  always #5
  begin
    vld = ($realtime - chg >= lat) && ($realtime - csFall >= RAND_NS);
    if (selW && !ctl.outGateN)
      busFaults++;
    if (rdOn && (dqOe & (ctl.byteWideN ? 16'hffff : 16'h7fff)) != 0)
      busFaults++;
  end

  // ****
  // Data pins
  // ****
  // Released pins flip every cycle, so stale data never looks valid.
  always #25 junk = ~junk;
  always @*
  begin
    if (!(rdOn && vld))
      dqIn = junk;
    else if (ctl.byteWideN)
      dqIn = addrOut[15:0] ^ 16'h5a3c;
    else
      dqIn = {junk[15:8], dqOut[15] ? 8'ha6 : 8'h59};
  end
endmodule // nfc_flash_model
`default_nettype wire

// >>> testbench/async_flash_bus_operations_bench.sv
// Self-checking bench for the host-side NOR flash bus controller.
`timescale 1ns/100ps
`default_nettype none
module async_flash_bus_operations_bench
  import nfc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic resetReq = 1'b0;
  logic writeProtReq = 1'b0;
  nfc_req_type req = '0;
  logic reqReady;
  logic rdValid;
  logic wrLow;
  logic [15:0] rdData;
  logic [15:0] dqOut;
  logic [15:0] dqOe;
  logic [15:0] dqIn;
  logic [15:0] wrData;
  logic [25:0] addrOut;
  logic [25:0] wrAddr;
  nfc_ctl_type ctl;
  int faults;
  int miscompares = 0;
  int checked = 0;

  nfc_host_ctrl dut
  (
    .clk(clk), .rst(rst), .req(req), .reqValid(reqValid),
    .resetReq(resetReq), .writeProtReq(writeProtReq),
    .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid),
    .ctl(ctl), .addrOut(addrOut), .dqOut(dqOut), .dqOe(dqOe),
    .dqIn(dqIn)
  );

  nfc_flash_model flash
  (
    .ctl(ctl), .addrOut(addrOut), .dqOut(dqOut), .dqOe(dqOe),
    .dqIn(dqIn), .faults(faults), .wrAddr(wrAddr), .wrData(wrData),
    .wrLow(wrLow)
  );

  // 40 MHz clock.
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // ****
  // Helpers
  // ****
  // Case equality keeps an unknown from ever passing as a match.
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
        got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Word reads give an address-keyed pattern; byte reads one of two codes.
  function automatic logic [15:0] exp_read(input logic bm,
    input logic [25:0] a);
    return bm ? {8'h00, a[0] ? 8'ha6 : 8'h59} : a[15:0] ^ 16'h5a3c;
  endfunction

  task automatic wait_ready();
    int n;
    for (n = 0; n < 200 && reqReady !== 1'b1; n++)
      @(negedge clk);
    check(reqReady, 1, "ready");
  endtask

  // One request, then the pins and the outcome are checked.
  task automatic op(input logic wr, input logic bm, input logic [25:0] a,
    input logic [15:0] d);
    int n;
    logic [15:0] m;
    m = bm ? 16'h00ff : 16'hffff;
    wait_ready();
    req = '{addr: a, wdata: d, write: wr, byteMode: bm};
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    for (n = 0; n < 40 && ctl.outGateN !== 1'b0 && ctl.writeStrobeN !== 1'b0;
      n++)
      @(negedge clk);
    check({ctl.chipSelN, ctl.outGateN, ctl.writeStrobeN, ctl.hardResetN,
      ctl.byteWideN}, {1'b0, wr, !wr, 1'b1, !bm}, "strobes");
    if (wr)
    begin
      wait_ready();
      if (bm)
        check(wrLow, a[0], "low addr");
      else
        check(wrAddr, a, "cmd addr");
      check(wrData & m, d & m, "cmd data");
    end
    else
    begin
      for (n = 0; n < 40 && rdValid !== 1'b1; n++)
        @(negedge clk);
      check({rdValid, rdData}, {1'b1, exp_read(bm, a)}, "read");
    end
    check(ctl.writeProtN, !writeProtReq, "protect pin");
  endtask

  task automatic hard_reset();
    wait_ready();
    resetReq = 1'b1;
    @(negedge clk);
    resetReq = 1'b0;
    repeat (2) @(negedge clk);
    check({ctl.hardResetN, ctl.chipSelN, ctl.outGateN, ctl.writeStrobeN,
      dqOe}, {4'b0111, 16'h0}, "reset pins");
  endtask

  // ****
  // Tests
  // ****
  initial
  begin
    int i;
    logic [25:0] a;
    i = $urandom(95964);
    repeat (20) @(negedge clk);
    check({ctl.hardResetN, ctl.chipSelN, dqOe}, 18'h10000, "rst");
    rst = 1'b0;
    $display("test reset done");
    // Page neighbours, a page edge, the top block and both byte lanes.
    op(0, 0, 26'h0, 16'h0);
    op(0, 0, 26'h1, 16'h0);
    op(0, 0, 26'hf, 16'h0);
    op(0, 0, 26'h10, 16'h0);
    op(1, 0, TOP_WORD_ADDR, 16'ha55a);
    op(0, 0, TOP_WORD_ADDR, 16'h0);
    op(0, 1, 26'h2e, 16'h0);
    op(0, 1, 26'h2f, 16'h0);
    op(1, 1, 26'h31, 16'h00c7);
    $display("test corners done");
    a = 26'h0;
    for (i = 0; i < 60; i++)
    begin
      writeProtReq = 1'($urandom);
      a = $urandom_range(0, 1) ? {a[25:4], 4'($urandom)} : 26'($urandom);
      op($urandom_range(0, 3) == 0, 1'($urandom), a, 16'($urandom));
    end
    $display("test random done");
    hard_reset();
    op(0, 0, 26'h5, 16'h0);
    op(1, 0, 26'h7, 16'h1234);
    $display("test wake done");
    check(faults, 0, "bus rules");
    finish_test();
  end

  // The run needs well under 100 us; this cuts a hang short.
  initial
  begin
    #400000;
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule // async_flash_bus_operations_bench
`default_nettype wire
